// file: rtl/can_tx_buffer_payload.sv
// AXI4-Lite register view and engine read port of three CAN transmit buffers
`timescale 1ns/1ns
// How it works
// - Each buffer has a read/write byte with extended identifier bits 15..8.
// - Each buffer has a read/write byte with extended identifier bits 7..0.
// - Each buffer holds eight read/write payload bytes, index zero to seven.
// - Length control bit 6 sets the outgoing frame's remote request bit.
// - Length control bits 3..0 give zero to eight bytes; above eight reserved.
// - Length control bits 7, 5 and 4 read zero and ignore writes.
// - Extended identifier bytes reach the engine only with extended ids on.
// - Setting send request clears status; a successful send clears request.
module can_tx_buffer_payload
  import can_txbuf_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Engine selection
  input wire logic [1:0] eng_sel,
  input wire logic [2:0] eng_byte_idx,
  // Engine events, one bit per buffer, one-cycle pulses
  input wire logic [NUM_BUFFERS-1:0] eng_sent,
  input wire logic [NUM_BUFFERS-1:0] eng_aborted,
  input wire logic [NUM_BUFFERS-1:0] eng_lost,
  input wire logic [NUM_BUFFERS-1:0] eng_error,
  // Frame contents toward the engine
  output logic [NUM_BUFFERS-1:0] send_request_flag,
  output logic extended_id_enable,
  output logic [15:0] eng_ext_id,
  output logic remote_request_select,
  output logic [3:0] eng_length,
  output logic [7:0] eng_byte,
  output logic eng_byte_valid
);
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic aw_have;
    logic [7:0] wbyte;
    logic wlane0;
    logic w_have;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [NUM_BUFFERS-1:0] req;
    logic ext_en;
    logic [15:0] ext_id;
    logic rtr;
    logic [3:0] len;
    logic [7:0] byte_out;
    logic byte_valid;
  } top_t;

  top_t t_q, t_d;

  // Slot contents
  logic [7:0] hi_w [NUM_BUFFERS];
  logic [7:0] lo_w [NUM_BUFFERS];
  logic [7:0] lc_w [NUM_BUFFERS];
  logic [7:0] ct_w [NUM_BUFFERS];
  logic [PAYLOAD_BYTES*8-1:0] dat_w [NUM_BUFFERS];
  logic [NUM_BUFFERS-1:0] xen_w;
  logic [NUM_BUFFERS-1:0] req_w;

  // Write strobe toward the slots
  logic wr_en;
  logic [1:0] wr_buf;
  logic [3:0] wr_idx;

  //////////////////////////////////////////////////////////////////////////
  // Three buffer slots
  for (genvar n = 0; n < NUM_BUFFERS; n++) begin : g_slot
    tx_buffer_slot u_slot (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(wr_en && wr_buf == 2'(n)),
      .wr_idx(wr_idx),
      .wr_data(t_q.wbyte),
      .sent(eng_sent[n]),
      .aborted(eng_aborted[n]),
      .lost(eng_lost[n]),
      .errored(eng_error[n]),
      .ext_hi_o(hi_w[n]),
      .ext_lo_o(lo_w[n]),
      .len_ctrl_o(lc_w[n]),
      .ctrl_o(ct_w[n]),
      .data_o(dat_w[n]),
      .ext_en_o(xen_w[n]),
      .req_o(req_w[n])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // Write path: commit once address and data are both held
  assign wr_buf = t_q.awaddr[BUF_SEL_MSB:BUF_SEL_LSB];
  assign wr_idx = t_q.awaddr[IDX_MSB:IDX_LSB];
  assign wr_en = t_q.aw_have && t_q.w_have && !t_q.bvalid &&
    t_q.wlane0 && wr_buf < 2'(NUM_BUFFERS) && wr_idx <= REG_PAYLOAD7;

  // Next state of bus and engine registers
  always_comb begin
    logic [1:0] rb;
    logic [3:0] ri;
    logic [7:0] rv;
    logic [1:0] es;
    logic [3:0] dlc;
    rb = s_axi_araddr[BUF_SEL_MSB:BUF_SEL_LSB];
    ri = s_axi_araddr[IDX_MSB:IDX_LSB];
    rv = 8'h00;
    es = eng_sel;
    dlc = 4'h0;
    t_d = t_q;
    // Address and data channels, either order
    if (s_axi_awvalid && t_q.awready) begin
      t_d.aw_have = 1'b1;
      t_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && t_q.wready) begin
      t_d.w_have = 1'b1;
      t_d.wbyte = s_axi_wdata[7:0];
      t_d.wlane0 = s_axi_wstrb[0];
    end
    if (t_q.bvalid && s_axi_bready) begin
      t_d.bvalid = 1'b0;
    end
    if (t_q.aw_have && t_q.w_have && !t_q.bvalid) begin
      t_d.aw_have = 1'b0;
      t_d.w_have = 1'b0;
      t_d.bvalid = 1'b1;
      t_d.bresp = (wr_buf < 2'(NUM_BUFFERS) && wr_idx <= REG_PAYLOAD7) ?
        RESP_OKAY : RESP_SLVERR;
    end
    t_d.awready = !t_d.aw_have && !t_d.bvalid;
    t_d.wready = !t_d.w_have && !t_d.bvalid;
    // Read channel
    if (t_q.rvalid && s_axi_rready) begin
      t_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && t_q.arready) begin
      t_d.rvalid = 1'b1;
      t_d.rresp = RESP_SLVERR;
      if (rb < 2'(NUM_BUFFERS) && ri <= REG_PAYLOAD7) begin
        t_d.rresp = RESP_OKAY;
        if (ri == REG_EXT_HIGH) begin
          rv = hi_w[rb];
        end else if (ri == REG_EXT_LOW) begin
          rv = lo_w[rb];
        end else if (ri == REG_LEN_CTRL) begin
          rv = lc_w[rb];
        end else if (ri == REG_CONTROL) begin
          rv = ct_w[rb];
        end else begin
          rv = dat_w[rb][8*(3'(ri - REG_PAYLOAD0)) +: 8];
        end
      end
      t_d.rdata = {24'h000000, rv};
    end
    t_d.arready = !t_d.rvalid;
    // Engine view of the selected buffer
    t_d.req = req_w;
    t_d.ext_en = 1'b0;
    t_d.ext_id = 16'h0000;
    t_d.rtr = 1'b0;
    t_d.len = 4'h0;
    t_d.byte_out = 8'h00;
    t_d.byte_valid = 1'b0;
    if (es < 2'(NUM_BUFFERS)) begin
      dlc = lc_w[es][DLC_MSB:0];
      t_d.ext_en = xen_w[es];
      if (xen_w[es]) begin
        t_d.ext_id = {hi_w[es], lo_w[es]};
      end
      t_d.rtr = lc_w[es][RTR_BIT];
      t_d.len = (dlc > MAX_DLC) ? MAX_DLC : dlc;
      t_d.byte_out = dat_w[es][8*eng_byte_idx +: 8];
      t_d.byte_valid = {1'b0, eng_byte_idx} < t_d.len;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign s_axi_awready = t_q.awready;
  assign s_axi_wready = t_q.wready;
  assign s_axi_bvalid = t_q.bvalid;
  assign s_axi_bresp = t_q.bresp;
  assign s_axi_arready = t_q.arready;
  assign s_axi_rvalid = t_q.rvalid;
  assign s_axi_rresp = t_q.rresp;
  assign s_axi_rdata = t_q.rdata;
  assign send_request_flag = t_q.req;
  assign extended_id_enable = t_q.ext_en;
  assign eng_ext_id = t_q.ext_id;
  assign remote_request_select = t_q.rtr;
  assign eng_length = t_q.len;
  assign eng_byte = t_q.byte_out;
  assign eng_byte_valid = t_q.byte_valid;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  a_ext_id_gated: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !extended_id_enable |-> eng_ext_id == 16'h0000)
    else $error("extended id shown while disabled");
  a_byte_in_length: assert property (@(posedge aclk)
    disable iff (!aresetn)
    eng_byte_valid == ({1'b0, $past(eng_byte_idx)} < eng_length))
    else $error("payload byte valid outside length");
  a_length_limit: assert property (@(posedge aclk)
    disable iff (!aresetn)
    eng_length <= MAX_DLC)
    else $error("length above eight bytes");
  a_bresp_held: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  c_write: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
  c_read: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready && s_axi_rdata != 32'h0);
  c_full_frame: cover property (@(posedge aclk) disable iff (!aresetn)
    eng_length == MAX_DLC && eng_byte_valid && remote_request_select);
endmodule : can_tx_buffer_payload

// file: rtl/can_txbuf_pkg.sv
// Constants shared by the transmit buffer payload block
package can_txbuf_pkg;
  localparam int NUM_BUFFERS = 3;
  localparam int PAYLOAD_BYTES = 8;
  localparam int ADDR_W = 8;
  // Address fields: buffer select and register index within a buffer
  localparam int BUF_SEL_MSB = 7;
  localparam int BUF_SEL_LSB = 6;
  localparam int IDX_MSB = 5;
  localparam int IDX_LSB = 2;
  // Register indexes within one buffer (byte address = index * 4)
  localparam logic [3:0] REG_EXT_HIGH = 4'h0;
  localparam logic [3:0] REG_EXT_LOW = 4'h1;
  localparam logic [3:0] REG_LEN_CTRL = 4'h2;
  localparam logic [3:0] REG_CONTROL = 4'h3;
  localparam logic [3:0] REG_PAYLOAD0 = 4'h4;
  localparam logic [3:0] REG_PAYLOAD7 = 4'hb;
  // Length control byte layout
  localparam int RTR_BIT = 6;
  localparam int DLC_MSB = 3;
  localparam logic [7:0] LEN_CTRL_MASK = 8'h4f;
  localparam logic [3:0] MAX_DLC = 4'h8;
  // Control and status byte layout
  localparam int CTRL_EXT_EN_BIT = 0;
  localparam int CTRL_REQ_BIT = 3;
  localparam int CTRL_ERR_BIT = 4;
  localparam int CTRL_LOST_BIT = 5;
  localparam int CTRL_ABT_BIT = 6;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : can_txbuf_pkg

// file: rtl/tx_buffer_slot.sv
// Storage and send flags of one transmit buffer
`timescale 1ns/1ns
module tx_buffer_slot
  import can_txbuf_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register write port
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [7:0] wr_data,
  // Protocol engine events
  input wire logic sent,
  input wire logic aborted,
  input wire logic lost,
  input wire logic errored,
  // Contents
  output logic [7:0] ext_hi_o,
  output logic [7:0] ext_lo_o,
  output logic [7:0] len_ctrl_o,
  output logic [7:0] ctrl_o,
  output logic [PAYLOAD_BYTES*8-1:0] data_o,
  output logic ext_en_o,
  output logic req_o
);
  typedef struct packed {
    logic [7:0] ext_hi;
    logic [7:0] ext_lo;
    logic [7:0] len_ctrl;
    logic [PAYLOAD_BYTES-1:0][7:0] data;
    logic ext_en;
    logic req;
    logic abt;
    logic lost;
    logic err;
  } slot_t;

  slot_t s_q, s_d;
  logic sw_req;

  //////////////////////////////////////////////////////////////////////////
  // Next state: send clear, software writes, then the other engine events
  assign sw_req = wr_en && wr_idx == REG_CONTROL && wr_data[CTRL_REQ_BIT];

  always_comb begin
    s_d = s_q;
    if (sent) begin
      s_d.req = 1'b0;
    end
    if (wr_en) begin
      unique case (wr_idx)
        REG_EXT_HIGH: s_d.ext_hi = wr_data;
        REG_EXT_LOW: s_d.ext_lo = wr_data;
        REG_LEN_CTRL: s_d.len_ctrl = wr_data & LEN_CTRL_MASK;
        REG_CONTROL: begin
          s_d.ext_en = wr_data[CTRL_EXT_EN_BIT];
          s_d.req = wr_data[CTRL_REQ_BIT];
          if (wr_data[CTRL_REQ_BIT]) begin
            s_d.abt = 1'b0;
            s_d.lost = 1'b0;
            s_d.err = 1'b0;
          end
        end
        default: begin
          if (wr_idx >= REG_PAYLOAD0 && wr_idx <= REG_PAYLOAD7) begin
            s_d.data[3'(wr_idx - REG_PAYLOAD0)] = wr_data;
          end
        end
      endcase
    end
    // Engine events set after the software clear, so they win
    if (aborted) begin
      s_d.abt = 1'b1;
    end
    if (lost) begin
      s_d.lost = 1'b1;
    end
    if (errored) begin
      s_d.err = 1'b1;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign ext_hi_o = s_q.ext_hi;
  assign ext_lo_o = s_q.ext_lo;
  assign len_ctrl_o = s_q.len_ctrl;
  assign data_o = s_q.data;
  assign ext_en_o = s_q.ext_en;
  assign req_o = s_q.req;
  always_comb begin
    ctrl_o = 8'h00;
    ctrl_o[CTRL_EXT_EN_BIT] = s_q.ext_en;
    ctrl_o[CTRL_REQ_BIT] = s_q.req;
    ctrl_o[CTRL_ERR_BIT] = s_q.err;
    ctrl_o[CTRL_LOST_BIT] = s_q.lost;
    ctrl_o[CTRL_ABT_BIT] = s_q.abt;
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  a_ext_hi_write: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wr_en && wr_idx == REG_EXT_HIGH |=> ext_hi_o == $past(wr_data))
    else $error("ext id high byte not stored");
  a_ext_lo_write: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wr_en && wr_idx == REG_EXT_LOW |=> ext_lo_o == $past(wr_data))
    else $error("ext id low byte not stored");
  a_payload_byte_write: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wr_en && wr_idx == REG_PAYLOAD0 + 4'h7 |=>
    data_o[PAYLOAD_BYTES*8-1 -: 8] == $past(wr_data))
    else $error("payload byte seven not stored");
  a_rtr_bit_store: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wr_en && wr_idx == REG_LEN_CTRL |=>
    len_ctrl_o[RTR_BIT] == $past(wr_data[RTR_BIT]))
    else $error("remote request bit not stored");
  a_dlc_store: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && wr_idx == REG_LEN_CTRL |=>
    len_ctrl_o[DLC_MSB:0] == $past(wr_data[DLC_MSB:0]))
    else $error("length code not stored");
  a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (len_ctrl_o & ~LEN_CTRL_MASK) == 8'h00)
    else $error("unimplemented length bits not zero");
  a_req_clears_status: assert property (@(posedge aclk)
    disable iff (!aresetn)
    sw_req && !aborted && !lost && !errored |=>
    req_o && ctrl_o[CTRL_ABT_BIT:CTRL_ERR_BIT] == 3'h0)
    else $error("request did not clear status");
  a_sent_clears_req: assert property (@(posedge aclk)
    disable iff (!aresetn)
    sent && !sw_req |=> !req_o)
    else $error("request not cleared after send");
  c_request: cover property (@(posedge aclk) disable iff (!aresetn)
    sw_req ##[1:20] sent);
endmodule : tx_buffer_slot

// file: test/can_engine_model.sv
// Behavioural CAN protocol engine reading the transmit buffers
`timescale 1ns/1ns
module can_engine_model
  import can_txbuf_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Commands from the bench
  input wire logic [1:0] sel_i,
  input wire logic [2:0] idx_i,
  input wire logic ev_go,
  input wire logic [1:0] ev_buf,
  input wire logic [1:0] ev_kind,
  // Toward the buffers
  output logic [1:0] eng_sel,
  output logic [2:0] eng_byte_idx,
  output logic [NUM_BUFFERS-1:0] eng_sent,
  output logic [NUM_BUFFERS-1:0] eng_aborted,
  output logic [NUM_BUFFERS-1:0] eng_lost,
  output logic [NUM_BUFFERS-1:0] eng_error
);
  // Registered view select; outcome pulses last exactly one cycle
  always_ff @(posedge aclk) begin
    eng_sel <= aresetn ? sel_i : 2'h3;
    eng_byte_idx <= idx_i;
    eng_sent <= '0;
    eng_aborted <= '0;
    eng_lost <= '0;
    eng_error <= '0;
    if (aresetn && ev_go) begin
      case (ev_kind)
        2'h0: eng_sent[ev_buf] <= 1'b1;
        2'h1: eng_aborted[ev_buf] <= 1'b1;
        2'h2: eng_lost[ev_buf] <= 1'b1;
        default: eng_error[ev_buf] <= 1'b1;
      endcase
    end
  end
endmodule : can_engine_model

// file: test/can_tx_buffer_payload_tb_top.sv
// Self-checking bench of the transmit buffer payload block
`timescale 1ns/1ns
module can_tx_buffer_payload_tb_top
  import can_txbuf_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ev_go = 1'b0, probe = 1'b0;
  logic late_b = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] sel = 2'h3, ev_buf = 2'h0, ev_kind = 2'h0;
  logic [2:0] idx = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, ext_en, rtr, bvld;
  logic [1:0] bresp, rresp, eng_sel;
  logic [31:0] rdata;
  logic [2:0] eng_byte_idx, sent, abt, lst, err, req;
  logic [15:0] ext_id;
  logic [3:0] len;
  logic [7:0] ebyte;
  int n_fail = 0, checked = 0;
  logic [33:0] rq[$], eq[$];
  logic [1:0] bq[$];
  logic [7:0] mem [3][12];
  logic [15:0] lf = 16'hba3a;

  can_tx_buffer_payload u_can_tx_buffer_payload (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .eng_sel(eng_sel), .eng_byte_idx(eng_byte_idx), .eng_sent(sent),
    .eng_aborted(abt), .eng_lost(lst), .eng_error(err),
    .send_request_flag(req), .extended_id_enable(ext_en),
    .eng_ext_id(ext_id), .remote_request_select(rtr), .eng_length(len),
    .eng_byte(ebyte), .eng_byte_valid(bvld));
  can_engine_model u_can_engine_model (.aclk(aclk), .aresetn(aresetn),
    .sel_i(sel), .idx_i(idx), .ev_go(ev_go), .ev_buf(ev_buf),
    .ev_kind(ev_kind), .eng_sel(eng_sel), .eng_byte_idx(eng_byte_idx),
    .eng_sent(sent), .eng_aborted(abt), .eng_lost(lst), .eng_error(err));

  // Clock of 10 ns period
  always #5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////
  // Compare one value and count it
  task automatic cmp(input string nm, input logic [33:0] e,
                     input logic [33:0] s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  // Print the verdict and stop
  task automatic conclude();
    // A note that never met its answer counts as a mismatch
    if (rq.size() + eq.size() + bq.size() != 0) begin
      n_fail++;
      $display("BAD pending expected 0 seen %0d",
               rq.size() + eq.size() + bq.size());
    end
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // Next pseudo-random byte
  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction : rnd

  // Byte address of a register index within a buffer
  function automatic logic [7:0] ad(input int b, input int i);
    return {b[1:0], i[3:0], 2'b00};
  endfunction : ad

  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic aw_ok = 1'b0;
    logic w_ok = 1'b0;
    bq.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= !late_b;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awready && !aw_ok) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (wready && !w_ok) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    while (!bvalid) @(posedge aclk);
    // Late acceptance: the response must stand until bready comes
    if (late_b) begin
      bready <= 1'b1;
      @(posedge aclk);
    end
    bready <= 1'b0;
  endtask : wr

  // Bus read with the expected word noted first
  task automatic rd(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    rq.push_back({er, 24'h0, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rready <= 1'b0;
  endtask : rd

  // Register write that also updates the expected contents
  task automatic put(input int b, input int i, input logic [7:0] d);
    logic [7:0] o;
    o = mem[b][3];
    if (i == 2) mem[b][i] = d & LEN_CTRL_MASK;
    else if (i == 3) mem[b][i] = {1'b0, d[3] ? 3'h0 : o[6:4], d[3], 2'h0,
                                  d[0]};
    else mem[b][i] = d;
    wr(ad(b, i), d, 4'h1, RESP_OKAY);
  endtask : put

  // Engine view of one byte, expectation worked out from the contents
  task automatic eng(input int b, input int i);
    logic [3:0] l;
    logic en;
    logic [30:0] v;
    @(posedge aclk);
    sel <= b[1:0];
    idx <= i[2:0];
    repeat (2) @(posedge aclk);
    v = 31'h0;
    // No buffer selected: all but the request flags read zero
    if (b < NUM_BUFFERS) begin
      en = mem[b][3][0];
      l = (mem[b][2][3:0] > MAX_DLC) ? MAX_DLC : mem[b][2][3:0];
      v = {en, en ? {mem[b][0], mem[b][1]} : 16'h0, mem[b][2][6], l,
           mem[b][4+i], i < l};
    end
    eq.push_back({mem[2][3][3], mem[1][3][3], mem[0][3][3], v});
    probe <= 1'b1;
    @(posedge aclk);
    probe <= 1'b0;
  endtask : eng

  // Engine outcome pulse on one buffer
  task automatic ev(input int b, input int k);
    @(posedge aclk);
    ev_buf <= b[1:0];
    ev_kind <= k[1:0];
    ev_go <= 1'b1;
    @(posedge aclk);
    ev_go <= 1'b0;
    if (k == 0) mem[b][3][3] = 1'b0;
    else mem[b][3][7-k] = 1'b1;
  endtask : ev

  ////////////////////////////////////////////////////////////////////////
  // Compare each answer with the oldest note
  always @(posedge aclk) begin
    if (bvalid && bready) begin
      cmp("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
    end
    if (rvalid && rready) begin
      cmp("rdata", rq.pop_front(), {rresp, rdata});
    end
    if (probe) cmp("engine", eq.pop_front(),
                   {req, ext_en, ext_id, rtr, len, ebyte, bvld});
  end

  // Watchdog against a hang
  initial begin
    #200000;
    n_fail++;
    conclude();
  end

  // Main sequence
  initial begin
    logic [7:0] d;
    foreach (mem[b, i]) mem[b][i] = 8'h00;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int b = 0; b < 3; b++) begin
      for (int i = 0; i < 12; i++) put(b, i, rnd());
    end
    foreach (mem[b, i]) rd(ad(b, i), mem[b][i], RESP_OKAY);
    wr(ad(3, 0), rnd(), 4'h1, RESP_SLVERR);
    wr(ad(0, 12), rnd(), 4'h1, RESP_SLVERR);
    late_b = 1'b1;
    wr(ad(0, 0), ~mem[0][0], 4'h0, RESP_OKAY);
    late_b = 1'b0;
    rd(ad(0, 0), mem[0][0], RESP_OKAY);
    rd(ad(3, 1), 8'h00, RESP_SLVERR);
    rd(ad(1, 15), 8'h00, RESP_SLVERR);
    for (int c = 0; c < 16; c++) begin
      d = rnd();
      d[3:0] = c[3:0];
      put(c % 3, 2, d);
      put(c % 3, 3, {4'h0, c[1], 2'h0, c[0]});
      for (int i = 0; i < 8; i++) eng(c % 3, i);
    end
    put(1, 3, 8'h09);
    for (int k = 1; k < 4; k++) ev(1, k);
    rd(ad(1, 3), mem[1][3], RESP_OKAY);
    put(1, 3, 8'h09);
    rd(ad(1, 3), mem[1][3], RESP_OKAY);
    ev(1, 0);
    rd(ad(1, 3), mem[1][3], RESP_OKAY);
    eng(1, 0);
    eng(3, 5);
    repeat (4) @(posedge aclk);
    conclude();
  end
endmodule : can_tx_buffer_payload_tb_top
